/* File: rtl/apc_pkg.sv */
// Package for the parallel conversion control block.
// Shared by both ends and the interface; assumes a 10 MHz clk_sys.
package apc_pkg;
  localparam int unsigned DATA_W        = 14;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CONV_MAX_NS   = 1150;
  localparam int unsigned CONV_TYP_NS   = 950;
  localparam int unsigned ACQ_MIN_NS    = 300;
  // Longest time rounds down, least time rounds up
  localparam int unsigned CONV_CYC      = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned ACQ_CYC       = (ACQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 4;
  localparam logic [DATA_W-1:0] RESULT_RST = 14'h0000;
  localparam logic [CNT_W-1:0]  CNT_ZERO   = 4'h0;

  typedef enum logic [1:0] {
    APC_MODE_ALWAYS = 2'b00,
    APC_MODE_READ   = 2'b01,
    APC_MODE_SLOW   = 2'b11,
    APC_MODE_ROM    = 2'b10
  } apc_mode_t;

  typedef enum logic [1:0] {
    APC_DEV_IDLE = 2'b00,
    APC_DEV_CONV = 2'b01,
    APC_DEV_DONE = 2'b11
  } apc_dev_state_t;

  typedef enum logic [1:0] {
    APC_HST_IDLE = 2'b00,
    APC_HST_STRB = 2'b01,
    APC_HST_WAIT = 2'b11,
    APC_HST_ACQ  = 2'b10
  } apc_hst_state_t;
endpackage

/* File: rtl/apc_if.sv */
// Pin-level link between the host and the converter.
// Data bus is three-state; the host qualifies it with the enable.
`timescale 1ns/100ps
interface apc_if;
  import apc_pkg::*;
  logic              chip_select_n;
  logic              read_n;
  logic              conversion_start_n;
  logic              busy_n;
  logic [DATA_W-1:0] data_out;
  logic              data_oe;

  modport dev (
    input  chip_select_n,
    input  read_n,
    input  conversion_start_n,
    output busy_n,
    output data_out,
    output data_oe
  );
  modport host (
    output chip_select_n,
    output read_n,
    output conversion_start_n,
    input  busy_n,
    input  data_out,
    input  data_oe
  );
endinterface

/* File: rtl/apc_buf2.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes a single clock; drain side may stall freely.
`timescale 1ns/100ps
module apc_buf2
  import apc_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_W
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             clk_en,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  logic [WIDTH-1:0] mem_q [2];
  logic             wr_q;
  logic             rd_q;
  logic [1:0]       cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'd0;
    end else if (clk_en) begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clk_en && push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule

/* File: rtl/apc_dev.sv */
// Converter end: start detection, conversion timing, result holding.
// Assumes link pins are synchronous to clk_sys; sample comes from a plain port.
//
// Summary of operation
// RULE_01: Start converts when start low, select low.
// RULE_02: Further starts ignored during conversion.
// RULE_03: Busy low for whole conversion.
// RULE_04: Falling start edge begins conversion.
// RULE_05: Select and read low: outputs always driven.
// RULE_06: Narrow low or high start pulse accepted.
// RULE_07: Outputs float until read strobe low.
// RULE_08: Host shares bus; read gates the data.
// RULE_09: Host ties read and start together.
// RULE_10: Host alone schedules every start.
// RULE_11: Busy low holds host in wait.
// RULE_12: Prior result shown during conversion.
// RULE_13: New result placed, then busy rises.
// RULE_14: Host raises strobe after busy, capturing.
// RULE_15: ROM strobe starts, returns previous result.
// RULE_16: Host waits for completion before next.
// RULE_17: Conversion ends within maximum conversion time.
// RULE_18: Host allows acquisition time between conversions.
// RULE_19: Result is fourteen-bit two's complement.
// RULE_20: Holding register updates only at completion.
`timescale 1ns/100ps
module apc_dev
  import apc_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic              clk_en,
  // Link
  apc_if.dev                     link,
  // Analog sample stand-in
  input  wire logic [DATA_W-1:0] sample_value,
  // Status
  output logic                   conv_active,
  output logic                   result_strobe
);
  apc_dev_state_t    state_q;
  logic              start_prev_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [DATA_W-1:0] hold_q;
  logic [DATA_W-1:0] sample_q;
  logic              busy_n_q;
  logic              oe_q;
  logic              start_fall;
  logic              sel_start;
  logic              in_idle;
  logic              in_conv;
  logic              in_done;
  logic              accept;
  logic              conv_last;
  logic              drive_req;

  // Edge of start qualified by select; a pulse of either polarity has one fall
  assign start_fall = start_prev_q && !link.conversion_start_n; // RULE_04 RULE_06
  assign sel_start  = start_fall && !link.chip_select_n; // RULE_01
  assign in_idle    = (state_q == APC_DEV_IDLE);
  assign in_conv    = (state_q == APC_DEV_CONV);
  assign in_done    = (state_q == APC_DEV_DONE);
  // Falls outside idle are dropped, never queued for later
  assign accept     = in_idle && sel_start; // RULE_02
  assign conv_last  = in_conv && (cnt_q == CNT_ZERO); // RULE_17
  // Tied-low select and read keep the bus driven at all times
  assign drive_req  = !link.chip_select_n && !link.read_n; // RULE_05 RULE_07

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      start_prev_q <= 1'b1;
    end else if (clk_en) begin
      start_prev_q <= link.conversion_start_n;
    end
  end

  // State only; the counter has its own block
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= APC_DEV_IDLE;
    end else if (clk_en) begin
      unique case (state_q)
        APC_DEV_IDLE: begin
          if (accept) begin
            state_q <= APC_DEV_CONV;
          end
        end
        APC_DEV_CONV: begin
          if (conv_last) begin
            state_q <= APC_DEV_DONE;
          end
        end
        APC_DEV_DONE: begin
          state_q <= APC_DEV_IDLE;
        end
        default: begin
          state_q <= APC_DEV_IDLE;
        end
      endcase
    end
  end

  // Loaded two short: the start and done cycles make up the rest
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= CNT_ZERO;
    end else if (clk_en) begin
      if (accept) begin
        cnt_q <= CNT_W'(CONV_CYC - 2); // RULE_17
      end else if (in_conv && !conv_last) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
    end
  end

  // Sample frozen at the start, like the track-and-hold
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sample_q <= RESULT_RST;
    end else if (clk_en && accept) begin
      sample_q <= sample_value; // RULE_19
    end
  end

  // Result lands one cycle ahead of busy rising
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hold_q <= RESULT_RST;
    end else if (clk_en && conv_last) begin
      hold_q <= sample_q; // RULE_13 RULE_20 RULE_12 RULE_15
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy_n_q <= 1'b1;
    end else if (clk_en) begin
      if (accept) begin
        busy_n_q <= 1'b0; // RULE_03 RULE_11
      end else if (in_done) begin
        busy_n_q <= 1'b1; // RULE_03 RULE_13
      end
    end
  end

  // Own flop so the status port never sees an inverter glitch
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      conv_active <= 1'b0;
    end else if (clk_en) begin
      if (accept) begin
        conv_active <= 1'b1; // RULE_03
      end else if (in_done) begin
        conv_active <= 1'b0; // RULE_03
      end
    end
  end

  // One cycle late against the strobes; hosts allow for it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      oe_q <= 1'b0;
    end else if (clk_en) begin
      oe_q <= drive_req; // RULE_05 RULE_07
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      result_strobe <= 1'b0;
    end else if (clk_en) begin
      result_strobe <= in_done;
    end
  end

  assign link.busy_n   = busy_n_q;
  assign link.data_out = hold_q;
  assign link.data_oe  = oe_q;
endmodule

/* File: rtl/apc_host.sv */
// Host end: issues strobes per wiring mode and captures results.
// Assumes the converter answers within the conversion time; one clock.
`timescale 1ns/100ps
module apc_host
  import apc_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic              clk_en,
  // Link
  apc_if.host                    link,
  // User control
  input  wire apc_mode_t         mode,
  input  wire logic              req_valid,
  output logic                   req_ready,
  // Result stream
  output logic                   res_valid,
  input  wire logic              res_ready,
  output logic [DATA_W-1:0]      res_data
);
  apc_hst_state_t    state_q;
  logic [CNT_W-1:0]  acq_q;
  logic              cs_n_q;
  logic              rd_n_q;
  logic              cv_n_q;
  logic              busy_prev_q;
  logic              cap_q;
  logic [DATA_W-1:0] cap_data_q;
  logic              buf_ready;
  logic              busy_rise;
  logic              tied;

  assign busy_rise = !busy_prev_q && link.busy_n;
  assign tied      = (mode == APC_MODE_SLOW) || (mode == APC_MODE_ROM);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy_prev_q <= 1'b1;
    end else if (clk_en) begin
      busy_prev_q <= link.busy_n;
    end
  end

  // Start only when a captured word has room; a full buffer stalls new starts
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= APC_HST_IDLE;
      acq_q   <= CNT_ZERO;
      cs_n_q  <= 1'b1;
      rd_n_q  <= 1'b1;
      cv_n_q  <= 1'b1;
    end else if (clk_en) begin
      unique case (state_q)
        APC_HST_IDLE: begin
          cs_n_q <= 1'b0;
          rd_n_q <= (mode == APC_MODE_ALWAYS) ? 1'b0 : 1'b1;
          if (req_valid && buf_ready) begin // RULE_10
            state_q <= APC_HST_STRB;
            cv_n_q  <= 1'b0;
            rd_n_q  <= tied || (mode == APC_MODE_ALWAYS) ? 1'b0 : 1'b1; // RULE_09
          end
        end
        APC_HST_STRB: begin
          state_q <= APC_HST_WAIT;
          // Slow memory keeps the strobe low through the wait
          if (mode != APC_MODE_SLOW) begin
            cv_n_q <= 1'b1;
            if (mode == APC_MODE_ROM) begin
              rd_n_q <= 1'b1; // RULE_15
            end
          end
        end
        APC_HST_WAIT: begin
          if (busy_rise) begin // RULE_16
            if (mode == APC_MODE_READ) begin
              rd_n_q <= 1'b0; // RULE_08
            end else begin
              cv_n_q <= 1'b1; // RULE_14
              rd_n_q <= (mode == APC_MODE_ALWAYS) ? 1'b0 : 1'b1;
              state_q <= APC_HST_ACQ;
              acq_q   <= CNT_W'(ACQ_CYC);
            end
          end else if (mode == APC_MODE_READ && !rd_n_q && link.data_oe) begin
            rd_n_q  <= 1'b1;
            state_q <= APC_HST_ACQ;
            acq_q   <= CNT_W'(ACQ_CYC);
          end
        end
        APC_HST_ACQ: begin
          if (acq_q == CNT_ZERO) begin // RULE_18
            state_q <= APC_HST_IDLE;
          end else begin
            acq_q <= acq_q - CNT_W'(1);
          end
        end
      endcase
    end
  end

  // Capture at busy rise, or on the gated read once the bus is driven
  // ROM takes the prior word while its short strobe still drives the bus
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cap_q      <= 1'b0;
      cap_data_q <= RESULT_RST;
    end else if (clk_en) begin
      cap_q <= 1'b0;
      if (state_q == APC_HST_WAIT && link.data_oe &&
          ((busy_rise && mode != APC_MODE_READ && mode != APC_MODE_ROM) ||
           (mode == APC_MODE_READ && !rd_n_q) ||
           (mode == APC_MODE_ROM && !link.busy_n))) begin
        cap_q      <= 1'b1; // RULE_05 RULE_11 RULE_15
        cap_data_q <= link.data_out;
      end
    end
  end

  apc_buf2 #(
    .WIDTH (DATA_W)
  ) u_buf (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .clk_en    (clk_en),
    .in_valid  (cap_q),
    .in_ready  (buf_ready),
    .in_data   (cap_data_q),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

  assign req_ready               = (state_q == APC_HST_IDLE) && buf_ready;
  assign link.chip_select_n      = cs_n_q;
  assign link.read_n             = rd_n_q;
  assign link.conversion_start_n = cv_n_q;
endmodule

/* File: verification/apc_checker.sv */
// Checker for the pins of the host-to-converter link.
// Assumes one clock domain and the async active-low rstn.
`timescale 1ns/100ps
module apc_checker
  import apc_pkg::*;
(
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              rstn,
  // Host strobes
  input wire logic              chip_select_n,
  input wire logic              read_n,
  input wire logic              conversion_start_n,
  // Converter outputs
  input wire logic              busy_n,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              data_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Past busy high twice keeps the completion cycle out
  chk_start_busy: assert property (
    $fell(conversion_start_n) && !chip_select_n && busy_n && $past(busy_n) |=> !busy_n)
    else $error("start not answered by busy");
  chk_busy_len: assert property (
    $fell(busy_n) |-> (!busy_n) [*8] ##1 (!busy_n) [*3] ##1 busy_n)
    else $error("busy low length wrong");
  chk_busy_cause: assert property (
    $fell(busy_n) |-> !$past(conversion_start_n) && !$past(chip_select_n))
    else $error("busy fell without a start");
  chk_data_update: assert property (
    $changed(data_out) |-> !busy_n ##1 busy_n)
    else $error("result changed outside completion");
  chk_prior_held: assert property (
    $fell(busy_n) |-> $stable(data_out) [*8])
    else $error("prior result not held");
  chk_oe_on: assert property (
    !chip_select_n && !read_n |=> data_oe)
    else $error("outputs not enabled");
  chk_oe_off: assert property (
    chip_select_n || read_n |=> !data_oe)
    else $error("outputs enabled without read");
  chk_strobe_release: assert property (
    $rose(busy_n) |-> ##[0:4] conversion_start_n)
    else $error("strobe not released after busy");
  chk_acq_gap: assert property (
    $fell(conversion_start_n) |->
      busy_n && $past(busy_n) && $past(busy_n, 2) && $past(busy_n, 3))
    else $error("start before acquisition time");
  chk_start_select: assert property (
    $fell(conversion_start_n) |-> !chip_select_n)
    else $error("start without select");

  cov_conv: cover property ($fell(busy_n));
  cov_slow: cover property ($rose(busy_n) && !read_n);
  cov_gated: cover property ($fell(read_n) && busy_n);
endmodule

/* File: verification/test_apc_parallel_conversion_control.sv */
// Testbench: host and converter joined by one link, and a second
// converter on its own link driven directly, breaking host rules.
`timescale 1ns/100ps
module test_apc_parallel_conversion_control;
  import apc_pkg::*;
  logic              clk_sys, rstn, clk_en, req_valid, req_ready;
  logic              res_valid, res_ready, conv_active, result_strobe, act_b;
  logic              last_busy;
  logic [DATA_W-1:0] sample_value, res_data, prev_q, cur_q;
  logic [DATA_W-1:0] exp_q [$];
  apc_mode_t         mode;
  apc_mode_t         ms [4] = '{APC_MODE_ALWAYS, APC_MODE_READ, APC_MODE_SLOW, APC_MODE_ROM};
  int                failures, n_tests, k;

  apc_if link();
  apc_if link_b();
  apc_dev i_apc_dev (.clk_sys, .rstn, .clk_en, .link(link), .sample_value,
    .conv_active, .result_strobe);
  apc_host i_apc_host (.clk_sys, .rstn, .clk_en, .link(link), .mode, .req_valid,
    .req_ready, .res_valid, .res_ready, .res_data);
  apc_dev i_apc_dev_b (.clk_sys, .rstn, .clk_en, .link(link_b), .sample_value,
    .conv_active(act_b), .result_strobe());
  apc_checker i_apc_checker (.clk_sys, .rstn, .chip_select_n(link.chip_select_n),
    .read_n(link.read_n), .conversion_start_n(link.conversion_start_n),
    .busy_n(link.busy_n), .data_out(link.data_out), .data_oe(link.data_oe));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic cmp_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word(DATA_W'(got), DATA_W'(exp));
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask

  // Mode changes only once the host is idle again
  task automatic convert(input apc_mode_t m, input logic [DATA_W-1:0] v);
    k = 0;
    while (req_ready !== 1'b1 && k < 100) begin tick(); k++; end
    if (k == 100) failures++;
    mode = m;
    sample_value = v;
    // ROM returns the word of the conversion before this one
    exp_q.push_back((m == APC_MODE_ROM) ? cur_q : v);
    cur_q = v;
    req_valid = 1'b1;
    tick();
    req_valid = 1'b0;
  endtask

  task automatic drain(input int n);
    res_ready = 1'b1;
    repeat (n) begin
      k = 0;
      while (res_valid !== 1'b1 && k < 100) begin tick(); k++; end
      if (k == 100) failures++;
      cmp_word(res_data, exp_q.pop_front());
      tick();
    end
    res_ready = 1'b0;
  endtask

  // Counts converter-b busy cycles; with refall set, a second fall lands mid-conversion
  task automatic count_b(input logic refall);
    int n;
    n = 0;
    for (int j = 0; j < 20; j++) begin
      tick();
      if (j == 0) link_b.conversion_start_n = 1'b1;
      if (j == 1) link_b.conversion_start_n = refall ? 1'b0 : 1'b1;
      n += act_b;
    end
    cmp_word(DATA_W'(n), 14'h000b);
  endtask

  always @(negedge clk_sys) begin
    if (rstn) begin
      cmp_bit(conv_active, ~link.busy_n);
      if (last_busy === 1'b1 && link.busy_n === 1'b0) begin
        cmp_word(link.data_out, prev_q);
        cmp_bit(result_strobe, 1'b0);
        if (mode == APC_MODE_SLOW) cmp_bit(link.read_n, 1'b0);
      end
      if (last_busy === 1'b0 && link.busy_n === 1'b1) begin
        cmp_word(link.data_out, cur_q);
        cmp_bit(result_strobe, 1'b1);
        prev_q = cur_q;
      end
      if (link.busy_n === 1'b0 && mode != APC_MODE_ROM) cmp_bit(link.data_oe, mode != APC_MODE_READ);
    end
    last_busy = link.busy_n;
  end

  // Run needs about 340 cycles; allow about six times that
  initial begin
    #200_000;
    failures++;
    print_verdict();
  end

  initial begin
    {clk_en, rstn, req_valid, res_ready, last_busy} = 5'b1_0001;
    {failures, n_tests, k} = '0;
    mode = APC_MODE_ALWAYS;
    {sample_value, prev_q, cur_q} = {3{RESULT_RST}};
    link_b.chip_select_n = 1'b1;
    link_b.read_n = 1'b1;
    link_b.conversion_start_n = 1'b1;
    void'($urandom(32'h0000_36cd));
    repeat (16) @(posedge clk_sys);
    #1 rstn = 1'b1;
    tick();
    for (int i = 0; i < 12; i++) begin
      convert(ms[i % 4], (i < 2) ? (i ? 14'h1fff : 14'h2000) : DATA_W'($urandom));
      drain(1);
    end
    // Stalled receiver: two words fill the buffer, so req_ready drops for a third
    convert(APC_MODE_SLOW, DATA_W'($urandom));
    convert(APC_MODE_SLOW, DATA_W'($urandom));
    repeat (30) tick();
    cmp_bit(req_ready, 1'b0);
    drain(2);
    // Start with select high must not convert
    link_b.conversion_start_n = 1'b0;
    repeat (3) tick();
    cmp_bit(act_b, 1'b0);
    link_b.conversion_start_n = 1'b1;
    link_b.chip_select_n = 1'b0;
    tick();
    link_b.conversion_start_n = 1'b0;
    count_b(1'b1);
    // Start line was left low; a one-cycle high pulse gives the next fall
    link_b.conversion_start_n = 1'b1;
    tick();
    link_b.conversion_start_n = 1'b0;
    count_b(1'b0);
    print_verdict();
  end
endmodule
